// ===== design/mev_pkg.sv
// Package for the meter event enable, flag and phase-source block
// Overview of operation
// - Bits 0-2 enable no-load interrupts per power type
// - Bits 3-8 enable missing zero-crossing interrupts
// - Bits 9-14 enable detected zero-crossing interrupts
// - Reset-complete always enabled; bit 15 inert
// - Bit 16 enables sag; phase reported
// - Bit 17 enables overcurrent; phase reported
// - Bit 18 enables overvoltage; phase reported
// - Bit 19 enables A-then-C phase order error
// - Bit 20 enables neutral mismatch over threshold
// - Bits 23, 24 enable peak period ends
// - Bit 25 enables configuration checksum change
// - Reserved enable bits zero; all reset disabled
// - Phase bits 3-5 name overcurrent phase
// - Phase bits 9-11 name overvoltage phase
// - Phase bits 12-14 name sag phase
// - Reserved phase bits read zero; reset zero
// - First enable bit 17 gates DSP-done
package mev_pkg;

	// Bus and datapath widths
	localparam int MEV_ADDR_W = 18;
	localparam int MEV_DATA_W = 32;
	localparam int MEV_MAG_W = 24;

	// Register indices; byte address is four times the index
	localparam logic [15:0] MEV_EN2_IDX = 16'hE50B;
	localparam logic [15:0] MEV_PHASE_IDX = 16'hE600;
	localparam logic [15:0] MEV_THRESH_IDX = 16'h4398;
	localparam logic [15:0] MEV_STAT2_IDX = 16'hE700;
	localparam logic [15:0] MEV_CLR2_IDX = 16'hE701;
	localparam logic [15:0] MEV_EN1_IDX = 16'hE702;
	localparam logic [15:0] MEV_STAT1_IDX = 16'hE703;
	localparam logic [15:0] MEV_CLR1_IDX = 16'hE704;

	// Byte addresses derived from the indices
	localparam logic [MEV_ADDR_W-1:0] MEV_EN2_ADDR = {MEV_EN2_IDX, 2'b00};
	localparam logic [MEV_ADDR_W-1:0] MEV_PHASE_ADDR = {MEV_PHASE_IDX, 2'b00};
	localparam logic [MEV_ADDR_W-1:0] MEV_THRESH_ADDR = {MEV_THRESH_IDX, 2'b00};
	localparam logic [MEV_ADDR_W-1:0] MEV_STAT2_ADDR = {MEV_STAT2_IDX, 2'b00};
	localparam logic [MEV_ADDR_W-1:0] MEV_CLR2_ADDR = {MEV_CLR2_IDX, 2'b00};
	localparam logic [MEV_ADDR_W-1:0] MEV_EN1_ADDR = {MEV_EN1_IDX, 2'b00};
	localparam logic [MEV_ADDR_W-1:0] MEV_STAT1_ADDR = {MEV_STAT1_IDX, 2'b00};
	localparam logic [MEV_ADDR_W-1:0] MEV_CLR1_ADDR = {MEV_CLR1_IDX, 2'b00};

	// Bit positions in the second enable and flag registers
	localparam int MEV_B_NOLOAD = 0;
	localparam int MEV_B_ZX_MISS = 3;
	localparam int MEV_B_ZX_DET = 9;
	localparam int MEV_B_RST_DONE = 15;
	localparam int MEV_B_SAG = 16;
	localparam int MEV_B_OVERCURR = 17;
	localparam int MEV_B_OVERVOLT = 18;
	localparam int MEV_B_PH_ORDER = 19;
	localparam int MEV_B_MISMATCH = 20;
	localparam int MEV_B_PEAK_I = 23;
	localparam int MEV_B_PEAK_V = 24;
	localparam int MEV_B_CRC = 25;
	// Bit position in the first enable and flag registers
	localparam int MEV_B_DSP_DONE = 17;

	// Field masks and reset values
	localparam logic [31:0] MEV_EN2_WMASK = 32'h039FFFFF;
	localparam logic [31:0] MEV_EN2_IRQ_MASK = 32'h039F7FFF;
	localparam logic [31:0] MEV_STAT2_MASK = 32'h039FFFFF;
	localparam logic [31:0] MEV_EN1_WMASK = 32'h00020000;
	localparam logic [31:0] MEV_REG_RST = 32'h00000000;
	localparam logic [15:0] MEV_PHASE_RST = 16'h0000;

	// Phase-source field positions: overcurrent, overvoltage, sag
	localparam int MEV_GRP_N = 3;
	localparam int MEV_PH_LSB [MEV_GRP_N] = '{3, 9, 12};
	localparam int MEV_PH_FLAG [MEV_GRP_N] = '{17, 18, 16};

	// Event pulses from the metering datapaths, one cycle each
	typedef struct packed {
		logic [2:0] noload;
		logic [5:0] zx_missing;
		logic [5:0] zx_detect;
		logic [2:0] volt_rise;
		logic reset_complete;
		logic [2:0] sag_phase;
		logic [2:0] overcurrent_phase;
		logic [2:0] overvoltage_phase;
		logic peak_curr;
		logic peak_volt;
		logic crc_change;
		logic dsp_cycle_done;
	} mev_events_t;

	// Neutral current comparison sample
	typedef struct packed {
		logic valid;
		logic signed [MEV_MAG_W-1:0] summed_phase_current;
		logic signed [MEV_MAG_W-1:0] neutral_current_sample;
	} mev_neutral_t;

	// Phase order watcher states
	typedef enum {
		MEV_SEQ_IDLE,
		MEV_SEQ_AFTER_A
	} mev_seq_t;

endpackage : mev_pkg

// ===== design/mev_event_ctrl.sv
// Meter event enable, sticky flags, phase sources and interrupt output
`timescale 1ns/1ps

module mev_event_ctrl
	import mev_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [MEV_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [MEV_DATA_W-1:0] pwdata,
	output logic [MEV_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire mev_events_t events,
	input wire mev_neutral_t neutral,
	output logic irq
);

	// Second enable register, stored bits only
	logic [31:0] en2_q;
	// Second sticky flag register
	logic [31:0] stat2_q;
	// Next value of the second flags
	logic [31:0] stat2_d;
	// First enable register, only the DSP-done bit lives
	logic [31:0] en1_q;
	// First sticky flag register
	logic [31:0] stat1_q;
	// Next value of the first flags
	logic [31:0] stat1_d;
	// Neutral mismatch threshold
	logic [MEV_MAG_W-1:0] thresh_q;
	// Phase-source fields per group
	logic [2:0] ph_grp_q [MEV_GRP_N];
	// Assembled phase-source word
	logic [15:0] phase_word;

	// APB answer registers
	logic [MEV_DATA_W-1:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;

	// Decode results
	logic [31:0] rd_val;
	logic addr_hit;
	logic wr_take;

	// Clear strobes from software, same layout as flags
	logic [31:0] clr2;
	logic [31:0] clr1;

	// Event vectors
	logic [31:0] set2;
	logic [31:0] set1;
	logic [2:0] grp_vec [MEV_GRP_N];

	// Phase order watcher
	mev_seq_t seq_q;
	mev_seq_t seq_d;
	logic seq_err;

	// Neutral mismatch comparator
	logic signed [MEV_MAG_W:0] nm_diff;
	logic [MEV_MAG_W:0] nm_mag;
	logic nm_evt;

	// Ports straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;

	// A write lands only at the access edge with ready high
	assign wr_take = psel & penable & pready_q & pwrite;

	// Read mux and address match
	always_comb begin
		rd_val = 32'h00000000;
		addr_hit = 1'b1;
		if (paddr == MEV_EN2_ADDR) begin
			// Bit 15 reads back what was written
			rd_val = en2_q;
		end else if (paddr == MEV_PHASE_ADDR) begin
			// Upper half and reserved bits read zero
			rd_val = {16'h0000, phase_word};
		end else if (paddr == MEV_THRESH_ADDR) begin
			// Narrow threshold sits in the low bits
			rd_val = {{(32-MEV_MAG_W){1'b0}}, thresh_q};
		end else if (paddr == MEV_STAT2_ADDR) begin
			// Sticky flags
			rd_val = stat2_q;
		end else if (paddr == MEV_CLR2_ADDR) begin
			// Write-only clear reads zero
			rd_val = 32'h00000000;
		end else if (paddr == MEV_EN1_ADDR) begin
			// First enable
			rd_val = en1_q;
		end else if (paddr == MEV_STAT1_ADDR) begin
			// First sticky flags
			rd_val = stat1_q;
		end else if (paddr == MEV_CLR1_ADDR) begin
			// Write-only clear reads zero
			rd_val = 32'h00000000;
		end else begin
			// Anything else is unmapped
			addr_hit = 1'b0;
		end
	end

	// APB answer: ready in the first access cycle, no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= MEV_REG_RST;
		end else if (psel && !penable) begin
			// Setup cycle: read data captured here, so a flag set
			// during the access cycle shows on the next read
			pready_q <= 1'b1;
			pslverr_q <= ~addr_hit;
			prdata_q <= (pwrite || !addr_hit) ? 32'h00000000 : rd_val;
		end else begin
			// Idle or finished access
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end
	end

	// Second enable register; reserved bits never store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en2_q <= MEV_REG_RST;
		end else if (wr_take && paddr == MEV_EN2_ADDR) begin
			// Bit 15 is kept for readback but gates nothing
			en2_q <= pwdata & MEV_EN2_WMASK;
		end
	end

	// First enable register; only the DSP-done bit is implemented
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en1_q <= MEV_REG_RST;
		end else if (wr_take && paddr == MEV_EN1_ADDR) begin
			en1_q <= pwdata & MEV_EN1_WMASK;
		end
	end

	// Mismatch threshold register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thresh_q <= '0;
		end else if (wr_take && paddr == MEV_THRESH_ADDR) begin
			thresh_q <= pwdata[MEV_MAG_W-1:0];
		end
	end

	// Clear strobes exist for one access edge only
	always_comb begin
		clr2 = 32'h00000000;
		clr1 = 32'h00000000;
		if (wr_take && paddr == MEV_CLR2_ADDR) begin
			clr2 = pwdata;
		end else if (wr_take && paddr == MEV_CLR1_ADDR) begin
			clr1 = pwdata;
		end
	end

	// Phase order: after an A voltage rise, C rising before B is an error
	always_comb begin
		seq_d = seq_q;
		seq_err = 1'b0;
		case (seq_q)
			MEV_SEQ_IDLE: begin
				// Wait for phase A to open a window
				if (events.volt_rise[0]) begin
					seq_d = MEV_SEQ_AFTER_A;
				end
			end
			MEV_SEQ_AFTER_A: begin
				// B and C together count as correct order
				if (events.volt_rise[1]) begin
					seq_d = MEV_SEQ_IDLE;
				end else if (events.volt_rise[2]) begin
					seq_err = 1'b1;
					seq_d = MEV_SEQ_IDLE;
				end else if (events.volt_rise[0]) begin
					// A again without B or C restarts the window
					seq_d = MEV_SEQ_AFTER_A;
				end
			end
			default: begin
				seq_d = MEV_SEQ_IDLE;
			end
		endcase
	end

	// Phase order watcher state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_q <= MEV_SEQ_IDLE;
		end else begin
			seq_q <= seq_d;
		end
	end

	// Neutral mismatch: sign-extend so the difference cannot overflow
	always_comb begin
		nm_diff = {neutral.summed_phase_current[MEV_MAG_W-1], neutral.summed_phase_current}
			- {neutral.neutral_current_sample[MEV_MAG_W-1], neutral.neutral_current_sample};
		nm_mag = nm_diff[MEV_MAG_W] ? (MEV_MAG_W+1)'(0) - nm_diff : nm_diff;
		// Strictly greater than the threshold
		nm_evt = neutral.valid && (nm_mag > {1'b0, thresh_q});
	end

	// Second flag set vector from the datapath pulses
	always_comb begin
		set2 = 32'h00000000;
		set2[MEV_B_NOLOAD +: 3] = events.noload;
		set2[MEV_B_ZX_MISS +: 6] = events.zx_missing;
		set2[MEV_B_ZX_DET +: 6] = events.zx_detect;
		set2[MEV_B_RST_DONE] = events.reset_complete;
		set2[MEV_B_SAG] = |events.sag_phase;
		set2[MEV_B_OVERCURR] = |events.overcurrent_phase;
		set2[MEV_B_OVERVOLT] = |events.overvoltage_phase;
		set2[MEV_B_PH_ORDER] = seq_err;
		set2[MEV_B_MISMATCH] = nm_evt;
		set2[MEV_B_PEAK_I] = events.peak_curr;
		set2[MEV_B_PEAK_V] = events.peak_volt;
		set2[MEV_B_CRC] = events.crc_change;
		set1 = 32'h00000000;
		set1[MEV_B_DSP_DONE] = events.dsp_cycle_done;
	end

	// Set wins over a clear in the same cycle, so no event is lost
	always_comb begin
		stat2_d = ((stat2_q & ~clr2) | set2) & MEV_STAT2_MASK;
		stat1_d = ((stat1_q & ~clr1) | set1) & MEV_EN1_WMASK;
	end

	// Sticky flag registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat2_q <= MEV_REG_RST;
			stat1_q <= MEV_REG_RST;
		end else begin
			stat2_q <= stat2_d;
			stat1_q <= stat1_d;
		end
	end

	// Group vectors in field order: overcurrent, overvoltage, sag
	always_comb begin
		grp_vec[0] = events.overcurrent_phase;
		grp_vec[1] = events.overvoltage_phase;
		grp_vec[2] = events.sag_phase;
	end

	// Phase sources load on the same edge as their main flag, and
	// accumulate until that flag is cleared, so software always sees
	// every phase that contributed since its last clear
	generate
		for (genvar g = 0; g < MEV_GRP_N; g++) begin : g_phase
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ph_grp_q[g] <= 3'h0;
				end else begin
					ph_grp_q[g] <= (clr2[MEV_PH_FLAG[g]] ? 3'h0 : ph_grp_q[g]) | grp_vec[g];
				end
			end
		end
	endgenerate

	// Assemble the phase-source word; reserved bits tie to zero
	always_comb begin
		phase_word = MEV_PHASE_RST;
		phase_word[MEV_PH_LSB[0] +: 3] = ph_grp_q[0];
		phase_word[MEV_PH_LSB[1] +: 3] = ph_grp_q[1];
		phase_word[MEV_PH_LSB[2] +: 3] = ph_grp_q[2];
	end

	// Interrupt level: enabled flags plus the ungated reset-complete
	// flag; one register stage keeps the pin glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (|(stat2_q & en2_q & MEV_EN2_IRQ_MASK))
				| stat2_q[MEV_B_RST_DONE]
				| (|(stat1_q & en1_q & MEV_EN1_WMASK));
		end
	end

endmodule : mev_event_ctrl

// ===== bench/mev_event_props.sv
// Checker for the meter event block ports
`timescale 1ns/1ps
module mev_event_props
	import mev_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [MEV_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [MEV_DATA_W-1:0] pwdata,
	input wire logic [MEV_DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire mev_events_t events,
	input wire mev_neutral_t neutral,
	input wire logic irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Write beat that lands
	wire wr_acc = psel && penable && pready && pwrite;
	logic [31:0] en2_q; // Enable shadow
	logic [23:0] th_q; // Threshold shadow
	logic [15:0] ph_q; // Phase-source shadow
	logic [15:0] clr_m;
	logic [31:0] ev_v;
	logic signed [24:0] dif;
	logic [24:0] mag;
	// Event pulses laid out as enable bits; mismatch magnitude one bit wider to avoid overflow
	always_comb begin
		clr_m = '0;
		if (wr_acc && paddr == MEV_CLR2_ADDR) clr_m = {1'h0, {3{pwdata[16]}}, {3{pwdata[18]}}, 3'h0, {3{pwdata[17]}}, 3'h0};
		ev_v = '0;
		ev_v[14:0] = {events.zx_detect, events.zx_missing, events.noload};
		ev_v[18:16] = {|events.overvoltage_phase, |events.overcurrent_phase, |events.sag_phase};
		ev_v[25:23] = {events.crc_change, events.peak_volt, events.peak_curr};
		dif = neutral.summed_phase_current - neutral.neutral_current_sample;
		mag = dif[24] ? 25'(-dif) : 25'(dif);
	end
	// Shadows follow landed writes; set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en2_q <= '0;
			th_q <= '0;
			ph_q <= '0;
		end else begin
			if (wr_acc && paddr == MEV_EN2_ADDR) en2_q <= pwdata & MEV_EN2_WMASK;
			if (wr_acc && paddr == MEV_THRESH_ADDR) th_q <= pwdata[23:0];
			ph_q <= (ph_q & ~clr_m) | {1'h0, events.sag_phase, events.overvoltage_phase, 3'h0, events.overcurrent_phase, 3'h0};
		end
	end
	property p_rdy;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready not a single cycle");
	property p_en2_rd;
		pready && !pwrite && paddr == MEV_EN2_ADDR |-> prdata == en2_q;
	endproperty
	a_en2_rd: assert property (p_en2_rd) else $error("enable readback wrong");
	property p_ph_rd;
		pready && !pwrite && paddr == MEV_PHASE_ADDR |-> prdata == {16'h0000, $past(ph_q)};
	endproperty
	a_ph_rd: assert property (p_ph_rd) else $error("phase readback wrong");
	property p_ev_irq;
		(ev_v & en2_q & MEV_EN2_IRQ_MASK) != 32'h0 && !wr_acc |-> ##2 irq;
	endproperty
	a_ev_irq: assert property (p_ev_irq) else $error("enabled event gave no irq");
	property p_rst_irq;
		events.reset_complete |-> ##2 irq;
	endproperty
	a_rst_irq: assert property (p_rst_irq) else $error("reset complete gave no irq");
	property p_mis_irq;
		neutral.valid && mag > {1'h0, th_q} && en2_q[MEV_B_MISMATCH] && !wr_acc |-> ##2 irq;
	endproperty
	a_mis_irq: assert property (p_mis_irq) else $error("mismatch gave no irq");
	property p_irq_cause;
		$rose(irq) |-> $past(|events, 2) || $past(neutral.valid, 2) || $past(wr_acc, 2);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
	property p_irq_hold;
		irq && !$past(wr_acc) |=> irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq fell without clear");
endmodule : mev_event_props

bind mev_event_ctrl mev_event_props u_props (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
	.prdata, .pready, .pslverr, .events, .neutral, .irq);

// ===== bench/tb_meter_event_mask_and_phase_flags.sv
// Testbench for the meter event enable, flag and phase-source block
`timescale 1ns/1ps
module tb_meter_event_mask_and_phase_flags
	import mev_pkg::*;
;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic [MEV_ADDR_W-1:0] paddr = '0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd_v;
	logic [31:0] rnd = 32'h0000A2CB; // Seed 41675
	logic pready, pslverr, irq, rd_e;
	mev_events_t ev = '0;
	mev_neutral_t neu = '0;
	logic [2:0] ph;
	int err_count = 0;
	int comparisons = 0;
	int cyc = 0;
	// 250 MHz
	always #2 pclk = ~pclk;
	mev_event_ctrl dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.events(ev), .neutral(neu), .irq(irq));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Pulse pattern for flag bit b; 26 is dsp done, 27 drives voltage rises
	function automatic mev_events_t ev_of(input int b, input logic [2:0] p);
		mev_events_t e;
		e = '0;
		if (b < 3) e.noload[b] = 1'h1;
		else if (b < 9) e.zx_missing[b-3] = 1'h1;
		else if (b < 15) e.zx_detect[b-9] = 1'h1;
		else if (b == 15) e.reset_complete = 1'h1;
		else if (b == 16) e.sag_phase = p;
		else if (b == 17) e.overcurrent_phase = p;
		else if (b == 18) e.overvoltage_phase = p;
		else if (b == 23) e.peak_curr = 1'h1;
		else if (b == 24) e.peak_volt = 1'h1;
		else if (b == 25) e.crc_change = 1'h1;
		else if (b == 26) e.dsp_cycle_done = 1'h1;
		else e.volt_rise = p;
		return e;
	endfunction : ev_of
	// Phase-source bits expected for flag bit b
	function automatic logic [31:0] ph_exp(input int b, input logic [2:0] p);
		if (b == 16) return {17'h0, p, 12'h000};
		if (b == 17) return {26'h0, p, 3'h0};
		if (b == 18) return {20'h0, p, 9'h000};
		return 32'h0;
	endfunction : ph_exp
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// One APB transfer; waits on pready with no assumed latency
	task automatic apb(input logic w, input logic [MEV_ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd_v = prdata;
		rd_e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic rchk(input string s, input logic [MEV_ADDR_W-1:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(s, e, rd_v);
	endtask : rchk
	// Irq is registered: settled by the second falling edge
	task automatic irq_is(input logic e);
		repeat (2) @(negedge pclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask : irq_is
	task automatic pulse(input mev_events_t e);
		@(posedge pclk);
		ev <= e;
		@(posedge pclk);
		ev <= '0;
	endtask : pulse
	task automatic nsamp(input logic [23:0] s, input logic [23:0] n);
		@(posedge pclk);
		neu <= {1'h1, s, n};
		@(posedge pclk);
		neu <= '0;
	endtask : nsamp
	task automatic end_of_test();
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test
	// Hang guard, well above the expected run
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 4000) begin
			err_count++;
			end_of_test();
		end
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		// Reset state, read-only phase register, unmapped place
		apb(1'h1, MEV_PHASE_ADDR, 32'hFFFFFFFF);
		rchk("phase_rst", MEV_PHASE_ADDR, 32'h0);
		rchk("en2_rst", MEV_EN2_ADDR, 32'h0);
		apb(1'h0, 18'h00004, 32'h0);
		chk("pslverr", 32'h1, {31'h0, rd_e});
		// Reserved enable bits forced high must read back low
		repeat (6) begin
			rnd = lfsr(rnd);
			apb(1'h1, MEV_EN2_ADDR, rnd | ~MEV_EN2_WMASK);
			rchk("en2", MEV_EN2_ADDR, rnd & MEV_EN2_WMASK);
		end
		// Each gated pulse event except DSP done, order error and mismatch: masked, then enabled, then cleared
		for (int b = 0; b < 26; b++) begin
			if (b == 15 || (b > 18 && b < 23)) continue;
			rnd = lfsr(rnd);
			ph = (rnd[2:0] == 3'h0) ? 3'h5 : rnd[2:0];
			apb(1'h1, MEV_EN2_ADDR, rnd & ~(32'h1 << b));
			pulse(ev_of(b, ph));
			irq_is(1'h0);
			rchk("stat2", MEV_STAT2_ADDR, 32'h1 << b);
			rchk("phase", MEV_PHASE_ADDR, ph_exp(b, ph));
			apb(1'h1, MEV_EN2_ADDR, 32'h1 << b);
			irq_is(1'h1);
			apb(1'h1, MEV_CLR2_ADDR, 32'h1 << b);
			irq_is(1'h0);
			rchk("phase_clr", MEV_PHASE_ADDR, 32'h0);
		end
		// Reset complete ignores its enable bit
		apb(1'h1, MEV_EN2_ADDR, 32'h00008000);
		pulse(ev_of(15, 3'h0));
		apb(1'h1, MEV_EN2_ADDR, 32'h0);
		irq_is(1'h1);
		apb(1'h1, MEV_CLR2_ADDR, 32'h00008000);
		irq_is(1'h0);
		// DSP done through the first enable register
		apb(1'h1, MEV_EN1_ADDR, 32'h00020000);
		pulse(ev_of(26, 3'h0));
		irq_is(1'h1);
		apb(1'h1, MEV_CLR1_ADDR, 32'h00020000);
		irq_is(1'h0);
		// A then C is an order error; A, B, C is not
		pulse(ev_of(27, 3'h1));
		pulse(ev_of(27, 3'h4));
		rchk("order_bad", MEV_STAT2_ADDR, 32'h00080000);
		apb(1'h1, MEV_CLR2_ADDR, 32'hFFFFFFFF);
		pulse(ev_of(27, 3'h1));
		pulse(ev_of(27, 3'h2));
		pulse(ev_of(27, 3'h4));
		rchk("order_ok", MEV_STAT2_ADDR, 32'h0);
		// Neutral mismatch: equal to threshold is quiet, one above trips
		rnd = lfsr(rnd);
		apb(1'h1, MEV_THRESH_ADDR, {16'h0000, rnd[15:0]});
		apb(1'h1, MEV_EN2_ADDR, 32'h00100000);
		nsamp(24'h000064 + {8'h00, rnd[15:0]}, 24'h000064);
		irq_is(1'h0);
		nsamp(24'h000064, 24'h000065 + {8'h00, rnd[15:0]});
		irq_is(1'h1);
		end_of_test();
	end
endmodule : tb_meter_event_mask_and_phase_flags
